//--- rtl/pfsr_status.sv
/*
 Per-function bus status register with its event capture, system error and
 interrupt gating. Holds one copy per function; instantiate once per function.
 Assumes the configuration write path gives a one-cycle write strobe with
 address and byte enables, and that bus events arrive on i_clk as pulses.
 The global reset is the only reset that clears the error flags.
*/
`timescale 1ns/100ps
module pfsr_status (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_cfg_write,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [1:0] i_cfg_byte_en,
   input wire logic [15:0] i_cfg_wdata,
   input wire pfsr_pkg::pfsr_events_s i_events,
   input wire pfsr_pkg::pfsr_command_s i_command,
   input wire logic i_bus_revision_compat_enable,
   input wire logic i_interrupt_pending,
   output logic [15:0] o_status,
   output logic o_serr_pulse,
   output logic o_intx_assert
);

   logic rst_sync1_q;
   logic rst_sync2_q;
   logic rst_n;

   // Reset release through two flip-flops
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_sync1_q <= 1'b0;
         rst_sync2_q <= 1'b0;
      end else begin
         rst_sync1_q <= 1'b1;
         rst_sync2_q <= rst_sync1_q;
      end
   end
   assign rst_n = rst_sync2_q;

   wire status_hit = i_cfg_write && (i_cfg_addr == pfsr_pkg::STATUS_OFFSET);
   wire [15:0] lane_mask = {{8{i_cfg_byte_en[1]}}, {8{i_cfg_byte_en[0]}}};
   wire [15:0] clear_vec = status_hit ? (i_cfg_wdata & lane_mask & pfsr_pkg::STICKY_MASK) : 16'h0000;

   wire serr_request = i_events.addr_parity_error & i_command.system_error_enable
                       & i_command.parity_response_enable;

   wire set_parity = i_events.addr_parity_error | i_events.data_parity_error;
   wire set_system = serr_request;
   wire set_data_parity = i_events.perr_seen_as_master & i_command.parity_response_enable;

   wire [4:0] set_vec;
   wire [4:0] clr_vec;
   wire [4:0] flag_vec;
   assign set_vec = {set_parity, set_system, i_events.master_abort_received,
                     i_events.target_abort_received, i_events.target_abort_signalled};
   assign clr_vec = clear_vec[15:11];

   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_flag
         pfsr_sticky_bit u_flag (
            .i_clk(i_clk),
            .i_rst_n(rst_n),
            .i_set(set_vec[g]),
            .i_clear(clr_vec[g]),
            .o_flag(flag_vec[g])
         );
      end
   endgenerate

   logic data_parity_flag;
   pfsr_sticky_bit u_data_parity (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_set(set_data_parity),
      .i_clear(clear_vec[pfsr_pkg::BIT_DATA_PARITY]),
      .o_flag(data_parity_flag)
   );

   wire int_status = i_interrupt_pending & i_bus_revision_compat_enable;
   wire intx_next = int_status & ~i_command.interrupt_disable;

   wire [15:0] status_next = {flag_vec, pfsr_pkg::DEVSEL_MEDIUM, data_parity_flag,
                              1'b0, 1'b0, 1'b0, 1'b1, int_status, 3'h0};

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_status <= pfsr_pkg::STATUS_RESET;
         o_serr_pulse <= 1'b0;
         o_intx_assert <= 1'b0;
      end else begin
         o_status <= status_next;
         o_serr_pulse <= serr_request;
         o_intx_assert <= intx_next;
      end
   end

   // Sticky flag views for the checks below
   wire [5:0] sticky_flags = {flag_vec, data_parity_flag};
   wire [5:0] sticky_set = {set_vec, set_data_parity};
   wire [5:0] sticky_clear = {clr_vec, clear_vec[pfsr_pkg::BIT_DATA_PARITY]};
   wire [5:0] sticky_keep = sticky_flags & ~sticky_clear;
   wire [5:0] sticky_view = {o_status[pfsr_pkg::BIT_DETECTED_PARITY:pfsr_pkg::BIT_SIGNALLED_TARGET_ABORT],
                             o_status[pfsr_pkg::BIT_DATA_PARITY]};

   // Cause sampled, flag flop, then visible word
   sequence s_system_shown;
      ##2 o_status[pfsr_pkg::BIT_SIGNALLED_SYSTEM];
   endsequence

   sequence s_master_abort_shown;
      ##2 o_status[pfsr_pkg::BIT_RECEIVED_MASTER_ABORT];
   endsequence

   sequence s_target_rec_shown;
      ##2 o_status[pfsr_pkg::BIT_RECEIVED_TARGET_ABORT];
   endsequence

   // Inputs that skip the flag flops, levels and the SERR request, show one edge later
   sequence s_int_shown;
      ##1 o_status[pfsr_pkg::BIT_INT_STATUS];
   endsequence

   sequence s_intx_raised;
      ##1 o_intx_assert;
   endsequence

   sequence s_serr_raised;
      ##1 o_serr_pulse;
   endsequence

   property p_clear;
      @(posedge i_clk) disable iff (!rst_n)
      (status_hit && i_cfg_byte_en[1] && i_cfg_wdata[13] && !i_events.master_abort_received)
      |=> ##1 !o_status[13];
   endproperty
   a_clear: assert property (p_clear) else $error("master abort flag not cleared");

   property p_parity;
      @(posedge i_clk) disable iff (!rst_n) set_parity |=> ##1 o_status[15];
   endproperty
   a_parity: assert property (p_parity) else $error("parity flag not set");

   property p_serr;
      @(posedge i_clk) disable iff (!rst_n)
      o_serr_pulse |-> $past(i_command.system_error_enable) && $past(i_command.parity_response_enable);
   endproperty
   a_serr: assert property (p_serr) else $error("SERR without both enables");

   property p_target_sig;
      @(posedge i_clk) disable iff (!rst_n) i_events.target_abort_signalled |=> ##1 o_status[11];
   endproperty
   a_target_sig: assert property (p_target_sig) else $error("signalled abort flag missing");

   property p_fixed;
      @(posedge i_clk) disable iff (!rst_n)
      o_status[10:9] == 2'h1 && o_status[7:5] == 3'h0 && o_status[4] && o_status[2:0] == 3'h0;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed status field wrong");

   property p_intx;
      @(posedge i_clk) disable iff (!rst_n) o_intx_assert |-> o_status[3];
   endproperty
   a_intx: assert property (p_intx) else $error("INTx without interrupt status");

   property p_compat;
      @(posedge i_clk) disable iff (!rst_n) !$past(i_bus_revision_compat_enable) |-> !o_status[3];
   endproperty
   a_compat: assert property (p_compat) else $error("interrupt status without compat");

   property p_set_wins;
      @(posedge i_clk) disable iff (!rst_n)
      (set_vec[0] && clr_vec[0]) |=> ##1 o_status[pfsr_pkg::BIT_SIGNALLED_TARGET_ABORT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat simultaneous set");

   property p_data_parity;
      @(posedge i_clk) disable iff (!rst_n)
      $rose(data_parity_flag) |-> $past(i_events.perr_seen_as_master) && $past(i_command.parity_response_enable);
   endproperty
   a_data_parity: assert property (p_data_parity) else $error("data parity flag unqualified");

   property p_zero_keeps;
      @(posedge i_clk) disable iff (!rst_n)
      status_hit |-> ##2 ((sticky_view & $past(sticky_keep, 2)) == $past(sticky_keep, 2));
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("status write dropped a kept flag");

   property p_system;
      @(posedge i_clk) disable iff (!rst_n)
      set_system |-> s_system_shown;
   endproperty
   a_system: assert property (p_system) else $error("signalled system error flag missing");

   property p_rise_cause;
      @(posedge i_clk) disable iff (!rst_n)
      (~$past(sticky_view) & sticky_view & ~$past(sticky_set, 2)) == 6'h00;
   endproperty
   a_rise_cause: assert property (p_rise_cause) else $error("status flag set without a cause");

   property p_master_abort;
      @(posedge i_clk) disable iff (!rst_n)
      i_events.master_abort_received |-> s_master_abort_shown;
   endproperty
   a_master_abort: assert property (p_master_abort) else $error("master abort flag missing");

   property p_target_rec;
      @(posedge i_clk) disable iff (!rst_n)
      i_events.target_abort_received |-> s_target_rec_shown;
   endproperty
   a_target_rec: assert property (p_target_rec) else $error("received target abort flag missing");

   property p_dp_refuse;
      @(posedge i_clk) disable iff (!rst_n)
      i_events.perr_seen_as_master && !i_command.parity_response_enable && !data_parity_flag |=> !data_parity_flag;
   endproperty
   a_dp_refuse: assert property (p_dp_refuse) else $error("data parity flag set while disabled");

   property p_hardwired;
      @(posedge i_clk) disable iff (!rst_n)
      !o_status[pfsr_pkg::BIT_BACK_TO_BACK] && !o_status[pfsr_pkg::BIT_USER_FEATURES];
   endproperty
   a_hardwired: assert property (p_hardwired) else $error("unsupported feature bit set");

   property p_low_speed;
      @(posedge i_clk) disable iff (!rst_n)
      !o_status[pfsr_pkg::BIT_HIGH_SPEED];
   endproperty
   a_low_speed: assert property (p_low_speed) else $error("high speed bit set");

   property p_capability_list_present;
      @(posedge i_clk) disable iff (!rst_n)
      o_status[pfsr_pkg::BIT_CAPABILITY_LIST];
   endproperty
   a_capability_list_present: assert property (p_capability_list_present) else $error("capability list bit clear");

   property p_intx_disable;
      @(posedge i_clk) disable iff (!rst_n)
      o_intx_assert |-> !$past(i_command.interrupt_disable);
   endproperty
   a_intx_disable: assert property (p_intx_disable) else $error("INTx while disabled");

   property p_int_raise;
      @(posedge i_clk) disable iff (!rst_n)
      i_interrupt_pending && i_bus_revision_compat_enable |-> s_int_shown;
   endproperty
   a_int_raise: assert property (p_int_raise) else $error("interrupt status missing");

   property p_intx_raise;
      @(posedge i_clk) disable iff (!rst_n)
      int_status && !i_command.interrupt_disable |-> s_intx_raised;
   endproperty
   a_intx_raise: assert property (p_intx_raise) else $error("INTx missing");

   property p_int_track;
      @(posedge i_clk) disable iff (!rst_n)
      $past(rst_n) && $past(i_command.interrupt_disable)
      |-> o_status[pfsr_pkg::BIT_INT_STATUS] == $past(int_status);
   endproperty
   a_int_track: assert property (p_int_track) else $error("interrupt status altered by disable");

   property p_reserved;
      @(posedge i_clk) disable iff (!rst_n)
      o_status[2:0] == 3'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved status bit set");

   property p_only_clear;
      @(posedge i_clk) disable iff (!rst_n)
      ($past(sticky_view) & ~sticky_view & ~$past(sticky_clear, 2)) == 6'h00;
   endproperty
   a_only_clear: assert property (p_only_clear) else $error("status flag lost without a write");

   property p_reset_value;
      @(posedge i_clk) disable iff (!rst_n)
      !$past(rst_n)
      |-> o_status == pfsr_pkg::STATUS_RESET && !o_serr_pulse && !o_intx_assert;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("outputs not at reset value");

   property p_serr_cause;
      @(posedge i_clk) disable iff (!rst_n)
      o_serr_pulse |-> $past(i_events.addr_parity_error);
   endproperty
   a_serr_cause: assert property (p_serr_cause) else $error("SERR without address parity error");

   property p_serr_raise;
      @(posedge i_clk) disable iff (!rst_n)
      serr_request |-> s_serr_raised;
   endproperty
   a_serr_raise: assert property (p_serr_raise) else $error("SERR missing");

endmodule

//--- rtl/pfsr_pkg.sv
/*
 Package for the per-function bus status register: offsets, bit positions,
 reset value and the event carrier struct.
 Assumes nothing beyond a SystemVerilog tool.
*/
package pfsr_pkg;

   localparam logic [7:0] STATUS_OFFSET = 8'h06;
   localparam logic [7:0] COMMAND_OFFSET = 8'h04;
   localparam logic [7:0] GEN_CTRL_OFFSET = 8'h86;
   localparam logic [15:0] STATUS_RESET = 16'h0210;

   localparam int BIT_DETECTED_PARITY = 15;
   localparam int BIT_SIGNALLED_SYSTEM = 14;
   localparam int BIT_RECEIVED_MASTER_ABORT = 13;
   localparam int BIT_RECEIVED_TARGET_ABORT = 12;
   localparam int BIT_SIGNALLED_TARGET_ABORT = 11;
   localparam int BIT_DEVSEL_LO = 9;
   localparam int BIT_DATA_PARITY = 8;
   localparam int BIT_BACK_TO_BACK = 7;
   localparam int BIT_USER_FEATURES = 6;
   localparam int BIT_HIGH_SPEED = 5;
   localparam int BIT_CAPABILITY_LIST = 4;
   localparam int BIT_INT_STATUS = 3;

   localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
   localparam logic [15:0] STICKY_MASK = 16'hF900;

   // Bus events reported by the function's bus engine, one-cycle pulses
   typedef struct packed {
      logic addr_parity_error;
      logic data_parity_error;
      logic perr_seen_as_master;
      logic master_abort_received;
      logic target_abort_received;
      logic target_abort_signalled;
   } pfsr_events_s;

   // Command register bits used by this block
   typedef struct packed {
      logic system_error_enable;
      logic parity_response_enable;
      logic interrupt_disable;
   } pfsr_command_s;

endpackage

//--- rtl/pfsr_sticky_bit.sv
/*
 One write-one-to-clear sticky flag. Set wins over a clear in the same cycle.
 Assumes a clock and an already synchronised active-low reset.
*/
`timescale 1ns/100ps
module pfsr_sticky_bit (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_set,
   input wire logic i_clear,
   output logic o_flag
);
   logic flag_q;
   logic flag_d;

   assign flag_d = i_set | (flag_q & ~i_clear);
   assign o_flag = flag_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule

//--- verification/pfsr_bus_agent.sv
/*
 Bus engine stand-in: issues the event pulses of the status register.
 Assumes the bench calls pulse() between clock edges.
*/
`timescale 1ns/100ps
module pfsr_bus_agent (
   input wire logic i_clk,
   output pfsr_pkg::pfsr_events_s o_events
);
   initial o_events = '0;
   // One-cycle event pulse launched just after an edge
   task automatic pulse(input pfsr_pkg::pfsr_events_s ev);
      @(posedge i_clk);
      #2;
      o_events = ev;
      @(posedge i_clk);
      #2;
      o_events = '0;
   endtask
endmodule

//--- verification/tb_pci_function_status_register.sv
/*
 Self-checking bench of the per-function status register.
 Assumes a two-cycle path from write or event to o_status.
*/
`timescale 1ns/100ps
module tb_pci_function_status_register;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic wr_q = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [1:0] be = 2'h0;
   logic [15:0] wd = 16'h0000;
   pfsr_pkg::pfsr_events_s ev;
   pfsr_pkg::pfsr_command_s cmd = '0;
   logic compat = 1'b0;
   logic pend = 1'b0;
   logic [15:0] st;
   logic serr;
   logic intx;
   int n_fail = 0;
   int num_checks = 0;
   int serr_seen = 0;
   localparam logic [0:4][5:0] EVS = {6'h20, 6'h10, 6'h04, 6'h02, 6'h01};
   localparam logic [0:4][3:0] BITS = {4'hF, 4'hF, 4'hD, 4'hC, 4'hB};
   always #12.5 i_clk = ~i_clk;
   always @(negedge i_clk) if (serr === 1'b1) serr_seen++;
   pfsr_status pfsr_status_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_cfg_write(wr_q), .i_cfg_addr(addr),
      .i_cfg_byte_en(be), .i_cfg_wdata(wd), .i_events(ev), .i_command(cmd),
      .i_bus_revision_compat_enable(compat), .i_interrupt_pending(pend), .o_status(st),
      .o_serr_pulse(serr), .o_intx_assert(intx));
   pfsr_bus_agent pfsr_bus_agent_i (.i_clk(i_clk), .o_events(ev));
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
      addr = a;
      be = b;
      wd = d;
      wr_q = 1'b1;
      step(1);
      wr_q = 1'b0;
      step(2);
   endtask
   task automatic t_flags();
      for (int i = 0; i < 5; i++) begin
         pfsr_bus_agent_i.pulse(pfsr_pkg::pfsr_events_s'(EVS[i]));
         step(2);
         check(st, 16'h0210 | (16'h0001 << BITS[i]));
         wr(8'h04, 2'h3, 16'hFFFF);
         wr(8'h06, 2'h1, 16'hFFFF);
         wr(8'h06, 2'h3, 16'h0000);
         check(st, 16'h0210 | (16'h0001 << BITS[i]));
         wr(8'h06, 2'h3, 16'h0001 << BITS[i]);
         check(st, 16'h0210);
      end
      $display("t_flags done");
   endtask
   task automatic t_serr();
      cmd = 3'h6;
      serr_seen = 0;
      pfsr_bus_agent_i.pulse(pfsr_pkg::pfsr_events_s'(6'h20));
      step(3);
      check(16'(serr_seen), 16'h0001);
      check(st, 16'hC210);
      wr(8'h06, 2'h3, 16'hC000);
      cmd = 3'h4;
      serr_seen = 0;
      pfsr_bus_agent_i.pulse(pfsr_pkg::pfsr_events_s'(6'h20));
      step(3);
      check(16'(serr_seen), 16'h0000);
      check(st, 16'h8210);
      wr(8'h06, 2'h3, 16'h8000);
      $display("t_serr done");
   endtask
   task automatic t_data_parity_reported();
      cmd = 3'h2;
      pfsr_bus_agent_i.pulse(pfsr_pkg::pfsr_events_s'(6'h18));
      step(2);
      check(st, 16'h8310);
      wr(8'h06, 2'h3, 16'h8100);
      cmd = 3'h0;
      pfsr_bus_agent_i.pulse(pfsr_pkg::pfsr_events_s'(6'h18));
      step(2);
      check(st, 16'h8210);
      wr(8'h06, 2'h3, 16'h8000);
      $display("t_data_parity_reported done");
   endtask
   task automatic t_int();
      compat = 1'b1;
      pend = 1'b1;
      step(2);
      check({st[15:1], intx}, 16'h0219);
      cmd = 3'h1;
      step(2);
      check({st[15:1], intx}, 16'h0218);
      compat = 1'b0;
      cmd = 3'h0;
      step(2);
      check({st[15:1], intx}, 16'h0210);
      pend = 1'b0;
      compat = 1'b1;
      step(2);
      check({st[15:1], intx}, 16'h0210);
      compat = 1'b0;
      $display("t_int done");
   endtask
   task automatic t_race();
      fork
         pfsr_bus_agent_i.pulse(pfsr_pkg::pfsr_events_s'(6'h01));
         begin
            step(1);
            wr(8'h06, 2'h3, 16'h0800);
         end
      join
      check(st, 16'h0A10);
      wr(8'h06, 2'h3, 16'h0800);
      check(st, 16'h0210);
      $display("t_race done");
   endtask
   task automatic t_reset();
      pfsr_bus_agent_i.pulse(pfsr_pkg::pfsr_events_s'(6'h04));
      step(2);
      check(st, 16'h2210);
      i_nrst = 1'b0;
      step(1);
      check(st, 16'h0210);
      check({14'h0000, serr, intx}, 16'h0000);
      i_nrst = 1'b1;
      step(3);
      check(st, 16'h0210);
      $display("t_reset done");
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      n_fail++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge i_clk);
      #2;
      i_nrst = 1'b1;
      step(3);
      check(st, 16'h0210);
      t_flags();
      t_serr();
      t_data_parity_reported();
      t_int();
      t_race();
      t_reset();
      summarize();
   end
endmodule
